/* core/ptprw_pkg.sv */
// constants, encodings and carrier types of the timing rewrite control
// assumes one core clock and a synchronous active-high reset
//
// Contract
// - action bits 1-0 select the timing operation
// - action bits 3-2 select which delay to add
// - action bits 5-4 carry the sequence command
// - sequence update reads entry picked by frame sequence index
// - used sequence entry increments by one
// - commands two, three mark delay request handling
// - request handling with one-step updates correction field
// - bit 6 copies source MAC into destination
// - bit 7 puts egress port MAC as source
// - each port holds time domain and mode
// - each port holds egress and two ingress delays
// - checksum update disable held per port
// - software advance presents next stamp entry
// - host and virtual ports have own mode
// - nonzero reserved field sets a sticky flag
// - software writes and reads all sequence entries
// - port module holds delay, enable, domain
// - correction field overflow sets sticky port flag
// - port module offers phase evaluation enable
// - replacement source MAC split low and high
// - two-step pushes egress entry then ingress entry
package ptprw_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int NUM_PORTS  = 6;
   localparam int PORT_W     = 4;
   localparam int CPU_PORT   = 6;
   localparam int PHY_PORTS  = 2;
   localparam int SEQ_DEPTH  = 256;
   localparam int SEQ_AW     = 8;
   localparam int SEQ_W      = 16;
   localparam int FIFO_DEPTH = 1024;
   localparam int FIFO_AW    = 10;
   localparam int TS_W       = 32;
   localparam int DLY_W      = 16;
   localparam int PRED_W     = 8;

   // action word fields
   localparam int ACT_TS_LSB    = 0;
   localparam int ACT_DLY_LSB   = 2;
   localparam int ACT_SEQ_LSB   = 4;
   localparam int ACT_S2D_BIT   = 6;
   localparam int ACT_SMAC_BIT  = 7;

   localparam logic [1:0] TS_NOP     = 2'h0;
   localparam logic [1:0] TS_ONE     = 2'h1;
   localparam logic [1:0] TS_TWO     = 2'h2;
   localparam logic [1:0] TS_TOD     = 2'h3;
   localparam logic [1:0] DLY_NONE   = 2'h0;
   localparam logic [1:0] DLY_EGR    = 2'h1;
   localparam logic [1:0] DLY_ING1   = 2'h2;
   localparam logic [1:0] DLY_ING2   = 2'h3;
   localparam logic [1:0] SEQ_NOP    = 2'h0;
   localparam logic [1:0] SEQ_UPDATE = 2'h1;

   // reset values
   localparam logic [DLY_W-1:0]  DLY_RST  = 16'h0000;
   localparam logic [PRED_W-1:0] PRED_RST = 8'h00;
   localparam logic [31:0]       MAC_RST  = 32'h0000_0000;

   typedef enum logic [3:0] {
      CFG_MODE   = 4'h0,
      CFG_EDLY   = 4'h1,
      CFG_IDLY1  = 4'h2,
      CFG_IDLY2  = 4'h3,
      CFG_SMAC_L = 4'h4,
      CFG_SMAC_H = 4'h5,
      CFG_CKSUM  = 4'h6,
      CFG_CPUVD  = 4'h7,
      CFG_PM     = 4'h8,
      CFG_PHY    = 4'h9,
      CFG_PHASE  = 4'hA
   } ptprw_cfg_sel_t;

   typedef struct packed {
      logic [1:0] domain;
      logic [1:0] mode;
   } ptprw_mode_t;

   typedef struct packed {
      logic              valid;
      logic [7:0]        action;
      logic [PORT_W-1:0] tx_port;
      logic [PORT_W-1:0] rx_port;
      logic [SEQ_AW-1:0] seq_idx;
      logic [47:0]       smac;
      logic [47:0]       dmac;
      logic              rsrv_nonzero;
      logic [TS_W-1:0]   egr_ts;
      logic [TS_W-1:0]   ing_ts;
   } ptprw_frame_t;

   typedef struct packed {
      logic              valid;
      logic [1:0]        ts_cmd;
      logic [DLY_W-1:0]  delay;
      logic              seq_insert;
      logic [SEQ_W-1:0]  seq_no;
      logic              dreq_proc;
      logic              cf_rx_time;
      logic [47:0]       dmac;
      logic [47:0]       smac;
      logic              cksum_dis;
      ptprw_mode_t       mode;
   } ptprw_rw_t;

   typedef struct packed {
      logic              valid;
      logic              egress;
      logic [PORT_W-1:0] port;
      logic [TS_W-1:0]   ts;
   } ptprw_stamp_t;

   typedef struct packed {
      logic [DLY_W-1:0] io_delay;
      logic             enable;
      logic [1:0]       domain;
   } ptprw_pm_cfg_t;

endpackage : ptprw_pkg

/* core/ptprw_stamp_fifo.sv */
// two-step stamp fifo with a held readout entry
// assumes pushes and advances come from logic on the same clock
`timescale 1ns/1ps
module ptprw_stamp_fifo (
   // clock and reset
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   // fill side
   input  wire logic                   i_push,
   input  wire ptprw_pkg::ptprw_stamp_t i_entry,
   output logic                        o_full,
   // drain side
   input  wire logic                   i_adv,
   output ptprw_pkg::ptprw_stamp_t     o_entry
);

   localparam int AW = ptprw_pkg::FIFO_AW;

   ptprw_pkg::ptprw_stamp_t mem [ptprw_pkg::FIFO_DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic        empty;
   logic        do_push;

   assign empty   = (wr_ptr == rd_ptr);
   assign o_full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign do_push = i_push && !o_full;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (do_push) begin
         mem[wr_ptr[AW-1:0]] <= i_entry;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_ptr <= '0;
      end else if (do_push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // advance pops into the readout entry
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rd_ptr  <= '0;
         o_entry <= '0;
      end else if (i_adv) begin
         if (empty) begin
            o_entry <= '0;
         end else begin
            o_entry       <= mem[rd_ptr[AW-1:0]];
            o_entry.valid <= 1'b1;
            rd_ptr        <= rd_ptr + 1'b1;
         end
      end
   end

endmodule : ptprw_stamp_fifo

/* core/ptprw_ctrl.sv */
// timing rewrite control: action decode, per-port config,
// sequence table, stamp fifo feed and sticky flags
// assumes frames, config writes and events all come on i_clock
`timescale 1ns/1ps
module ptprw_ctrl (
   // clock and reset
   input  wire logic                    i_clock,
   input  wire logic                    i_rst,
   // frame action in
   input  wire ptprw_pkg::ptprw_frame_t i_frame,
   output logic                         o_frame_ready,
   // rewrite command out
   output ptprw_pkg::ptprw_rw_t         o_rw,
   // config write
   input  wire logic                    i_cfg_we,
   input  wire ptprw_pkg::ptprw_cfg_sel_t i_cfg_sel,
   input  wire logic [3:0]              i_cfg_port,
   input  wire logic [31:0]             i_cfg_data,
   // sequence table access
   input  wire logic                    i_seq_we,
   input  wire logic                    i_seq_re,
   input  wire logic [7:0]              i_seq_idx,
   input  wire logic [15:0]             i_seq_wdata,
   output logic [15:0]                  o_seq_rdata,
   // stamp fifo
   input  wire logic                    i_stamp_adv,
   output ptprw_pkg::ptprw_stamp_t      o_stamp,
   output logic                         o_stamp_full,
   // sticky flags
   input  wire logic [5:0]              i_cf_ovf,
   input  wire logic [5:0]              i_rsrv_clr,
   input  wire logic [5:0]              i_ovf_clr,
   output logic [5:0]                   o_rsrv_flags,
   output logic [5:0]                   o_ovf_flags,
   // port module settings
   output ptprw_pkg::ptprw_pm_cfg_t     o_pm_cfg [6],
   output logic [5:0]                   o_phase_en,
   output logic [7:0]                   o_phy_pred [2]
);

   localparam int NP = ptprw_pkg::NUM_PORTS;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ING  = 1'b1
   } ptprw_state_t;

   ////////////////////////////////////////////////////////////////////////
   // per-port rewriter settings
   ptprw_pkg::ptprw_mode_t  port_mode [NP];
   logic [15:0]             edly      [NP];
   logic [15:0]             idly1     [NP];
   logic [15:0]             idly2     [NP];
   logic [31:0]             smac_low  [NP];
   logic [15:0]             smac_high [NP];
   logic [NP-1:0]           cksum_dis;
   ptprw_pkg::ptprw_mode_t  cpu_mode;
   ptprw_pkg::ptprw_mode_t  vd_mode;

   logic [ptprw_pkg::SEQ_W-1:0] seq_tab [ptprw_pkg::SEQ_DEPTH];

   ptprw_state_t            state;
   ptprw_pkg::ptprw_stamp_t ing_entry;
   ptprw_pkg::ptprw_stamp_t push_entry;
   logic                    push;
   logic                    take;
   logic                    two_step;
   logic [1:0]              ts_cmd;
   logic [1:0]              dly_cmd;
   logic [1:0]              seq_cmd;
   logic [15:0]             seq_cur;
   logic                    seq_upd;

   // mode of any port, host and virtual ones too
   function automatic ptprw_pkg::ptprw_mode_t mode_of(
      input logic [3:0] port
   );
      ptprw_pkg::ptprw_mode_t m;
      m = '0;
      if (port < 4'(NP)) begin
         m = port_mode[port[2:0]];
      end else if (port == 4'(ptprw_pkg::CPU_PORT)) begin
         m = cpu_mode;
      end else begin
         m = vd_mode;
      end
      return m;
   endfunction : mode_of

   // write aimed at this front port
   function automatic logic hit(
      input ptprw_pkg::ptprw_cfg_sel_t sel,
      input int                        p
   );
      return i_cfg_we && (i_cfg_sel == sel) && (i_cfg_port == 4'(p));
   endfunction : hit

   // front-port index, others fold to zero
   function automatic logic [2:0] pidx(input logic [3:0] port);
      return (port < 4'(NP)) ? port[2:0] : 3'h0;
   endfunction : pidx

   ////////////////////////////////////////////////////////////////////////
   // per-port configuration registers
   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++) begin : g_port
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               port_mode[gp] <= '0;
            end else if (hit(ptprw_pkg::CFG_MODE, gp)) begin
               port_mode[gp] <= i_cfg_data[3:0];
            end
         end

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               edly[gp]  <= ptprw_pkg::DLY_RST;
               idly1[gp] <= ptprw_pkg::DLY_RST;
               idly2[gp] <= ptprw_pkg::DLY_RST;
            end else begin
               if (hit(ptprw_pkg::CFG_EDLY, gp)) begin
                  edly[gp] <= i_cfg_data[15:0];
               end
               if (hit(ptprw_pkg::CFG_IDLY1, gp)) begin
                  idly1[gp] <= i_cfg_data[15:0];
               end
               if (hit(ptprw_pkg::CFG_IDLY2, gp)) begin
                  idly2[gp] <= i_cfg_data[15:0];
               end
            end
         end

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               smac_low[gp]  <= ptprw_pkg::MAC_RST;
               smac_high[gp] <= 16'h0000;
            end else begin
               if (hit(ptprw_pkg::CFG_SMAC_L, gp)) begin
                  smac_low[gp] <= i_cfg_data;
               end
               if (hit(ptprw_pkg::CFG_SMAC_H, gp)) begin
                  smac_high[gp] <= i_cfg_data[15:0];
               end
            end
         end

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               cksum_dis[gp] <= 1'b0;
            end else if (hit(ptprw_pkg::CFG_CKSUM, gp)) begin
               cksum_dis[gp] <= i_cfg_data[0];
            end
         end

         // port module side
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               o_pm_cfg[gp]   <= '0;
               o_phase_en[gp] <= 1'b0;
            end else begin
               if (hit(ptprw_pkg::CFG_PM, gp)) begin
                  o_pm_cfg[gp] <= i_cfg_data[18:0];
               end
               if (hit(ptprw_pkg::CFG_PHASE, gp)) begin
                  o_phase_en[gp] <= i_cfg_data[0];
               end
            end
         end

         // sticky flags, set beats clear
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               o_rsrv_flags[gp] <= 1'b0;
            end else if (take && i_frame.rsrv_nonzero &&
                         i_frame.rx_port == 4'(gp)) begin
               o_rsrv_flags[gp] <= 1'b1;
            end else if (i_rsrv_clr[gp]) begin
               o_rsrv_flags[gp] <= 1'b0;
            end
         end

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               o_ovf_flags[gp] <= 1'b0;
            end else if (i_cf_ovf[gp]) begin
               o_ovf_flags[gp] <= 1'b1;
            end else if (i_ovf_clr[gp]) begin
               o_ovf_flags[gp] <= 1'b0;
            end
         end
      end

      for (gp = 0; gp < ptprw_pkg::PHY_PORTS; gp++) begin : g_phy
         // software fills before using stamps
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               o_phy_pred[gp] <= ptprw_pkg::PRED_RST;
            end else if (hit(ptprw_pkg::CFG_PHY, gp)) begin
               o_phy_pred[gp] <= i_cfg_data[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         cpu_mode <= '0;
         vd_mode  <= '0;
      end else if (i_cfg_we && i_cfg_sel == ptprw_pkg::CFG_CPUVD) begin
         cpu_mode <= i_cfg_data[3:0];
         vd_mode  <= i_cfg_data[7:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // action decode
   assign o_frame_ready = (state == ST_IDLE);
   assign take          = i_frame.valid && o_frame_ready;

   assign ts_cmd  = i_frame.action[ptprw_pkg::ACT_TS_LSB +: 2];
   assign dly_cmd = i_frame.action[ptprw_pkg::ACT_DLY_LSB +: 2];
   assign seq_cmd = i_frame.action[ptprw_pkg::ACT_SEQ_LSB +: 2];

   assign two_step = take && (ts_cmd == ptprw_pkg::TS_TWO);
   assign seq_upd  = take && (seq_cmd == ptprw_pkg::SEQ_UPDATE);

   assign seq_cur  = seq_tab[i_frame.seq_idx];

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_rw <= '0;
      end else begin
         o_rw.valid      <= take;
         o_rw.ts_cmd     <= ts_cmd;
         o_rw.seq_insert <= (seq_cmd == ptprw_pkg::SEQ_UPDATE);
         o_rw.seq_no     <= seq_cur;
         o_rw.dreq_proc  <= seq_cmd[1];
         o_rw.cf_rx_time <= seq_cmd[1] &&
                            (ts_cmd == ptprw_pkg::TS_ONE);
         o_rw.cksum_dis  <= cksum_dis[pidx(i_frame.tx_port)];
         o_rw.mode       <= mode_of(i_frame.tx_port);

         case (dly_cmd)
            ptprw_pkg::DLY_NONE:
               o_rw.delay <= 16'h0000;
            ptprw_pkg::DLY_EGR:
               o_rw.delay <= edly[pidx(i_frame.tx_port)];
            ptprw_pkg::DLY_ING1:
               o_rw.delay <= idly1[pidx(i_frame.rx_port)];
            ptprw_pkg::DLY_ING2:
               o_rw.delay <= idly2[pidx(i_frame.rx_port)];
            default:
               o_rw.delay <= 16'h0000;
         endcase

         if (i_frame.action[ptprw_pkg::ACT_S2D_BIT]) begin
            o_rw.dmac <= i_frame.smac;
         end else begin
            o_rw.dmac <= i_frame.dmac;
         end
         if (i_frame.action[ptprw_pkg::ACT_SMAC_BIT]) begin
            o_rw.smac <= {smac_high[pidx(i_frame.tx_port)],
                          smac_low[pidx(i_frame.tx_port)]};
         end else begin
            o_rw.smac <= i_frame.smac;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequence table; write beats increment
   always_ff @(posedge i_clock) begin
      if (i_seq_we) begin
         seq_tab[i_seq_idx] <= i_seq_wdata;
      end else if (seq_upd) begin
         seq_tab[i_frame.seq_idx] <= seq_cur + 16'h0001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_seq_rdata <= 16'h0000;
      end else if (i_seq_re) begin
         o_seq_rdata <= seq_tab[i_seq_idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-step: egress now, ingress next cycle
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state     <= ST_IDLE;
         ing_entry <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (two_step) begin
                  state            <= ST_ING;
                  ing_entry.valid  <= 1'b1;
                  ing_entry.egress <= 1'b0;
                  ing_entry.port   <= i_frame.rx_port;
                  ing_entry.ts     <= i_frame.ing_ts;
               end
            end
            ST_ING: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      push_entry = ing_entry;
      push       = 1'b0;
      if (state == ST_ING) begin
         push = 1'b1;
      end else if (two_step) begin
         push              = 1'b1;
         push_entry.valid  = 1'b1;
         push_entry.egress = 1'b1;
         push_entry.port   = i_frame.tx_port;
         push_entry.ts     = i_frame.egr_ts;
      end
   end

   ptprw_stamp_fifo u_fifo (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_push  (push),
      .i_entry (push_entry),
      .o_full  (o_stamp_full),
      .i_adv   (i_stamp_adv),
      .o_entry (o_stamp)
   );

endmodule : ptprw_ctrl

/* sim/ptprw_ctrl_sva.sv */
// port assertions of the timing rewrite control
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module ptprw_ctrl_chk (
   // clock and reset
   input wire logic                    i_clock,
   input wire logic                    i_rst,
   // frame path
   input wire ptprw_pkg::ptprw_frame_t i_frame,
   input wire logic                    o_frame_ready,
   input wire ptprw_pkg::ptprw_rw_t    o_rw,
   // sticky flags
   input wire logic [5:0]              i_cf_ovf,
   input wire logic [5:0]              i_ovf_clr,
   input wire logic [5:0]              o_rsrv_flags,
   input wire logic [5:0]              o_ovf_flags
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   logic take;
   assign take = i_frame.valid & o_frame_ready;
   sequence s_two_take;
      take && i_frame.action[1:0] == 2'h2;
   endsequence
   sequence s_block_one;
      !o_frame_ready ##1 o_frame_ready;
   endsequence
   ////////////////////////////////////////
   chk_rw_follows: assert property (take |=> o_rw.valid)
      else $error("rewrite command missing");
   chk_rw_only_take: assert property (!take |=> !o_rw.valid)
      else $error("spurious rewrite command");
   chk_ts_decode: assert property (take |=>
      o_rw.ts_cmd == $past(i_frame.action[1:0]))
      else $error("timing command wrong");
   chk_seq_flag: assert property (take |=>
      o_rw.seq_insert == ($past(i_frame.action[5:4]) == 2'h1))
      else $error("sequence insert wrong");
   chk_dreq_mark: assert property (take |=>
      o_rw.dreq_proc == $past(i_frame.action[5]) &&
      o_rw.cf_rx_time == ($past(i_frame.action[5]) &&
                          $past(i_frame.action[1:0]) == 2'h1))
      else $error("request marking wrong");
   chk_dmac_copy: assert property (take && i_frame.action[6] |=>
      o_rw.dmac == $past(i_frame.smac))
      else $error("source not copied");
   chk_dmac_keep: assert property (take && !i_frame.action[6] |=>
      o_rw.dmac == $past(i_frame.dmac))
      else $error("destination altered");
   chk_two_block: assert property (s_two_take |=> s_block_one)
      else $error("two-step did not stall");
   chk_rsrv_set: assert property (take && i_frame.rsrv_nonzero &&
      i_frame.rx_port == 4'h2 |=> o_rsrv_flags[2])
      else $error("reserved flag not set");
   chk_ovf_set: assert property (i_cf_ovf[5] |=> o_ovf_flags[5])
      else $error("overflow flag not set");
   chk_ovf_hold: assert property (o_ovf_flags[5] && !i_ovf_clr[5]
      |=> o_ovf_flags[5])
      else $error("overflow flag lost");
endmodule : ptprw_ctrl_chk

bind ptprw_ctrl ptprw_ctrl_chk u_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_frame(i_frame),
   .o_frame_ready(o_frame_ready), .o_rw(o_rw), .i_cf_ovf(i_cf_ovf),
   .i_ovf_clr(i_ovf_clr), .o_rsrv_flags(o_rsrv_flags),
   .o_ovf_flags(o_ovf_flags));

/* sim/ptprw_ana_model.sv */
// frame source in place of the analyzer
// assumes the ready handshake of the rewrite control
`timescale 1ns/1ps
module ptprw_ana_model (
   // clock
   input  wire logic               i_clock,
   // frame handshake
   input  wire logic               i_frame_ready,
   output ptprw_pkg::ptprw_frame_t o_frame
);
   initial o_frame = '0;
   // holds frame until ready is seen, for at most 8 cycles
   task automatic send(input ptprw_pkg::ptprw_frame_t f, input int gap,
                       output bit ok);
      ptprw_pkg::ptprw_frame_t idle;
      idle       = ~f;
      idle.valid = 1'b0;
      f.valid    = 1'b1;
      ok         = 1'b0;
      repeat (gap + 1) @(posedge i_clock);
      o_frame <= f;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(negedge i_clock);
         ok = i_frame_ready;
         @(posedge i_clock);
      end
      o_frame <= idle;
   endtask : send
endmodule : ptprw_ana_model

/* sim/tb.sv */
// self-checking bench of the timing rewrite control
// assumes the analyzer model and bound checker
`timescale 1ns/1ps
module tb;
   logic                      clk, rst, ready, full, cfg_we;
   logic                      seq_we, seq_re, adv;
   ptprw_pkg::ptprw_frame_t   frame;
   ptprw_pkg::ptprw_rw_t      rw, got;
   ptprw_pkg::ptprw_cfg_sel_t cfg_sel;
   ptprw_pkg::ptprw_stamp_t   stamp;
   ptprw_pkg::ptprw_pm_cfg_t  pm_cfg [6];
   logic [3:0]                cfg_port;
   logic [31:0]               cfg_data;
   logic [7:0]                seq_idx;
   logic [7:0]                phy_pred [2];
   logic [15:0]               seq_wd, seq_rd;
   logic [5:0]                cf_ovf, rsrv_clr, ovf_clr;
   logic [5:0]                rsrv_fl, ovf_fl, phase_en;
   int                        fail_count, compares;

   ptprw_ana_model ana (.i_clock(clk), .i_frame_ready(ready),
                        .o_frame(frame));
   ptprw_ctrl uut (.i_clock(clk), .i_rst(rst), .i_frame(frame),
      .o_frame_ready(ready), .o_rw(rw), .i_cfg_we(cfg_we),
      .i_cfg_sel(cfg_sel), .i_cfg_port(cfg_port), .i_cfg_data(cfg_data),
      .i_seq_we(seq_we), .i_seq_re(seq_re), .i_seq_idx(seq_idx),
      .i_seq_wdata(seq_wd), .o_seq_rdata(seq_rd), .i_stamp_adv(adv),
      .o_stamp(stamp), .o_stamp_full(full), .i_cf_ovf(cf_ovf),
      .i_rsrv_clr(rsrv_clr), .i_ovf_clr(ovf_clr), .o_rsrv_flags(rsrv_fl),
      .o_ovf_flags(ovf_fl), .o_pm_cfg(pm_cfg), .o_phase_en(phase_en),
      .o_phy_pred(phy_pred));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic cfg(input ptprw_pkg::ptprw_cfg_sel_t s,
                      input logic [3:0] p, input logic [31:0] d);
      @(posedge clk);
      cfg_we <= 1'b1; cfg_sel <= s; cfg_port <= p; cfg_data <= d;
      @(posedge clk);
      cfg_we <= 1'b0;
   endtask : cfg

   task automatic seq(input logic w, input logic [7:0] i,
                      input logic [15:0] d);
      @(posedge clk);
      seq_we <= w; seq_re <= !w; seq_idx <= i; seq_wd <= d;
      @(posedge clk);
      seq_we <= 1'b0; seq_re <= 1'b0;
      @(negedge clk);
   endtask : seq

   task automatic frm(input logic [7:0] act, input logic [3:0] tx, rx,
                      input logic [7:0] idx, input logic rsv, input int gap);
      ptprw_pkg::ptprw_frame_t f;
      bit                      ok, seen;
      f = '{1'b1, act, tx, rx, idx, 48'h0A0B0C0D0E0F, 48'h111122223333,
            rsv, 32'h1111_0000, 32'h2222_0000};
      ana.send(f, gap, ok);
      seen = 1'b0;
      for (int n = 0; n < 4 && ok && !seen; n++) begin
         @(negedge clk);
         seen = rw.valid;
      end
      got = rw;
      if (!seen) begin
         chk("rw_valid", 64'h0, 64'h1);
         end_sim();
      end
   endtask : frm

   task automatic advance(input logic [63:0] exp);
      @(posedge clk);
      adv <= 1'b1;
      @(posedge clk);
      adv <= 1'b0;
      @(negedge clk);
      chk("stamp", stamp, exp);
   endtask : advance
   ////////////////////////////////////////
   task automatic t_reset;
      chk("ready", ready, 64'h1);
      chk("full", full, 64'h0);
      chk("stamp", stamp, 64'h0);
      chk("flags", {rsrv_fl, ovf_fl}, 64'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_two;
      frm(8'h02, 4'h1, 4'h4, 8'h00, 1'b0, 0);
      advance(64'h31_1111_0000);
      advance(64'h24_2222_0000);
      advance(64'h0);
      $display("test two-step done");
   endtask : t_two

   task automatic t_decode;
      logic [15:0] d [4];
      d = '{16'h0000, 16'h0111, 16'h0222, 16'h0333};
      cfg(ptprw_pkg::CFG_EDLY, 4'h1, 32'h0111);
      cfg(ptprw_pkg::CFG_EDLY, 4'h2, 32'h0444);
      cfg(ptprw_pkg::CFG_IDLY1, 4'h2, 32'h0222);
      cfg(ptprw_pkg::CFG_IDLY1, 4'h1, 32'h0555);
      cfg(ptprw_pkg::CFG_IDLY2, 4'h2, 32'h0333);
      for (int i = 0; i < 16; i++) begin
         frm({4'h0, i[3:0]}, 4'h1, 4'h2, 8'h00, 1'b0, i % 3);
         chk("ts_cmd", got.ts_cmd, i[1:0]);
         chk("delay", got.delay, d[i[3:2]]);
      end
      frm(8'h21, 4'h1, 4'h2, 8'h00, 1'b0, 0);
      chk("dreq", {got.dreq_proc, got.cf_rx_time}, 64'h3);
      frm(8'h32, 4'h1, 4'h2, 8'h00, 1'b0, 0);
      chk("dreq", {got.dreq_proc, got.cf_rx_time}, 64'h2);
      $display("test decode done");
   endtask : t_decode

   task automatic t_seq;
      seq(1'b1, 8'h05, 16'h00FF);
      seq(1'b1, 8'h06, 16'h1234);
      seq(1'b0, 8'h06, 16'h0);
      chk("seq_rd", seq_rd, 64'h1234);
      frm(8'h10, 4'h1, 4'h2, 8'h05, 1'b0, 0);
      chk("seq_no", {got.seq_insert, got.seq_no}, 64'h1_00FF);
      seq(1'b0, 8'h05, 16'h0);
      chk("seq_rd", seq_rd, 64'h0100);
      seq(1'b0, 8'h06, 16'h0);
      chk("seq_rd", seq_rd, 64'h1234);
      $display("test seq done");
   endtask : t_seq

   task automatic t_mac_mode;
      cfg(ptprw_pkg::CFG_SMAC_L, 4'h3, 32'hCAFE_0001);
      cfg(ptprw_pkg::CFG_SMAC_H, 4'h3, 32'h42);
      cfg(ptprw_pkg::CFG_MODE, 4'h3, 32'hB);
      cfg(ptprw_pkg::CFG_CKSUM, 4'h3, 32'h1);
      cfg(ptprw_pkg::CFG_CPUVD, 4'h0, 32'h5A);
      frm(8'hC0, 4'h3, 4'h2, 8'h00, 1'b0, 0);
      chk("dmac", got.dmac, 48'h0A0B_0C0D_0E0F);
      chk("smac", got.smac, 48'h0042_CAFE_0001);
      chk("mode", {got.cksum_dis, got.mode}, 64'h1B);
      frm(8'h00, 4'h6, 4'h2, 8'h00, 1'b0, 0);
      chk("host", got.mode, 64'hA);
      frm(8'h00, 4'h9, 4'h2, 8'h00, 1'b0, 0);
      chk("virt", got.mode, 64'h5);
      $display("test mac done");
   endtask : t_mac_mode

   task automatic t_flags;
      frm(8'h00, 4'h1, 4'h2, 8'h00, 1'b1, 0);
      chk("rsrv", rsrv_fl, 64'h04);
      @(posedge clk);
      rsrv_clr <= 6'h04;
      cf_ovf   <= 6'h20;
      @(posedge clk);
      rsrv_clr <= 6'h00;
      cf_ovf   <= 6'h00;
      @(negedge clk);
      chk("flags", {rsrv_fl, ovf_fl}, 64'h020);
      @(posedge clk);
      ovf_clr <= 6'h20;
      @(posedge clk);
      ovf_clr <= 6'h00;
      @(negedge clk);
      chk("ovf", ovf_fl, 64'h0);
      $display("test flags done");
   endtask : t_flags

   task automatic t_port;
      cfg(ptprw_pkg::CFG_PM, 4'h2, 32'h0005_5E6D);
      cfg(ptprw_pkg::CFG_PHY, 4'h1, 32'h3C);
      cfg(ptprw_pkg::CFG_PHASE, 4'h4, 32'h1);
      @(negedge clk);
      chk("pm_cfg", pm_cfg[2], 64'h5_5E6D);
      chk("phy", {phy_pred[1], phy_pred[0]}, 64'h3C00);
      chk("phase", phase_en, 64'h10);
      $display("test port done");
   endtask : t_port
   ////////////////////////////////////////
   initial begin
      rst = 1'b1; cfg_we = 1'b0; cfg_sel = ptprw_pkg::CFG_MODE;
      cfg_port = 4'h0; cfg_data = 32'h0; seq_we = 1'b0; seq_re = 1'b0;
      seq_idx = 8'h00; seq_wd = 16'h0; adv = 1'b0; cf_ovf = 6'h00;
      rsrv_clr = 6'h00; ovf_clr = 6'h00; fail_count = 0; compares = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_reset();
      t_two();
      t_decode();
      t_seq();
      t_mac_mode();
      t_flags();
      t_port();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim();
   end
endmodule : tb
